// ### lif_pkg.sv
package lif_pkg;

    // Register offsets on the serial register port.
    localparam logic [7:0] LIF_OFF_MAP_ONE       = 8'h0c;
    localparam logic [7:0] LIF_OFF_MAP_TWO       = 8'h0d;
    localparam logic [7:0] LIF_OFF_PWM_DIVISOR   = 8'h0e;
    localparam logic [7:0] LIF_OFF_SEQ_CONFIG    = 8'h0f;
    localparam logic [7:0] LIF_OFF_SHARED_IDLE   = 8'h10;
    localparam logic [7:0] LIF_OFF_RELEASE_DELAY = 8'h11;
    localparam logic [7:0] LIF_OFF_ENG1_LEVEL    = 8'h12;
    localparam logic [7:0] LIF_OFF_ENG1_TIMING   = 8'h13;
    localparam logic [7:0] LIF_OFF_ENG2_LEVEL    = 8'h14;
    localparam logic [7:0] LIF_OFF_ENG2_TIMING   = 8'h15;
    localparam logic [7:0] LIF_OFF_PWR_REST      = 8'h16;
    localparam logic [7:0] LIF_OFF_PWR_ACTIVE    = 8'h17;
    localparam logic [7:0] LIF_OFF_PWR_LOW       = 8'h18;
    localparam logic [7:0] LIF_OFF_PWR_TIMING    = 8'h19;
    localparam logic [7:0] LIF_OFF_PWR_PULSE     = 8'h1a;
    localparam logic [7:0] LIF_OFF_PWR_MODE      = 8'h1b;
    localparam logic [7:0] LIF_OFF_FIRST         = 8'h0c;
    localparam logic [7:0] LIF_OFF_LAST          = 8'h1b;

    // Field positions.
    localparam int LIF_SEQ_MODE_LSB    = 0;
    localparam int LIF_SEQ_LOG_BIT     = 2;
    localparam int LIF_SEQ_RSVD_BIT    = 3;
    localparam int LIF_SEQ_REPEAT_LSB  = 4;
    localparam int LIF_HI_NIBBLE_LSB   = 4;
    localparam int LIF_LO_NIBBLE_LSB   = 0;
    localparam int LIF_PWR_ENABLE_BIT  = 1;
    localparam int LIF_PWR_CHANNEL     = 7;

    localparam logic [7:0] LIF_REG_RESET = 8'h00;

    // Sequence mode encodings.
    localparam logic [1:0] LIF_SEQ_SINGLE   = 2'h0;
    localparam logic [1:0] LIF_SEQ_CONTINUE = 2'h1;
    localparam logic [1:0] LIF_SEQ_REP_LOW  = 2'h2;
    localparam logic [1:0] LIF_SEQ_REP_HIGH = 2'h3;

    // Timing, from a 5 ns system clock.
    localparam int LIF_CLK_PERIOD_PS  = 5000;
    localparam int LIF_OSC_PERIOD_PS  = 500000;
    localparam int LIF_MEAS_TIME_US   = 648;
    localparam int LIF_STEP_BASE_US   = 250;
    localparam int LIF_ENG_STEP_US    = 500;
    localparam int LIF_DELAY_UNIT_MS  = 256;
    localparam int LIF_OSC_CYCLES     = LIF_OSC_PERIOD_PS / LIF_CLK_PERIOD_PS;
    localparam int LIF_MEAS_CYCLES    = (LIF_MEAS_TIME_US * 1000000) / LIF_CLK_PERIOD_PS;
    localparam int LIF_BASE_CYCLES    = (LIF_STEP_BASE_US * 1000000) / LIF_CLK_PERIOD_PS;
    localparam int LIF_ENG_STEP_TICKS = LIF_ENG_STEP_US / LIF_STEP_BASE_US;
    localparam int LIF_DELAY_CYCLES   = (LIF_DELAY_UNIT_MS * 1000000) / LIF_CLK_PERIOD_PS * 1000;
    localparam int LIF_PWM_SLOT_CLOCKS = 255;

    typedef enum logic [1:0] {LIF_ENG_REST, LIF_ENG_ACTIVE, LIF_ENG_DELAY} lif_eng_state_e;
    typedef enum logic {LIF_FRAME_MEASURE, LIF_FRAME_DRIVE} lif_frame_e;

endpackage

// ### lif_fade_engine.sv
`timescale 1ns/10ps
module lif_fade_engine
    import lif_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       step_tick_in,
    input  wire logic       delay_tick_in,
    input  wire logic       active_in,
    input  wire logic [7:0] on_level_in,
    input  wire logic [7:0] rest_level_in,
    input  wire logic [7:0] fade_in_time_in,
    input  wire logic [7:0] fade_out_time_in,
    input  wire logic [3:0] delay_n_in,
    input  wire logic [1:0] seq_mode_in,
    input  wire logic [3:0] repeat_in,
    input  wire logic       log_fade_in,
    output logic      [7:0] level_out
);

    lif_eng_state_e state;
    logic           dir_up;
    logic [3:0]     reps_left;
    logic [3:0]     delay_cnt;
    logic [7:0]     step_cnt;
    logic [7:0]     target;
    logic [7:0]     target_q;
    logic [7:0]     step_len;
    logic [7:0]     diff;
    logic [7:0]     amount;
    logic [7:0]     swing;
    logic           going_up;

    assign swing = dir_up ? on_level_in : rest_level_in;

    always_comb
    begin
        target = rest_level_in;
        unique case (state)
            LIF_ENG_REST:  target = rest_level_in;
            LIF_ENG_DELAY: target = on_level_in;
            LIF_ENG_ACTIVE:
            begin
                unique case (seq_mode_in)
                    LIF_SEQ_SINGLE:   target = on_level_in;
                    LIF_SEQ_CONTINUE: target = swing;
                    LIF_SEQ_REP_LOW:  target = (reps_left != 4'h0) ? swing : rest_level_in;
                    LIF_SEQ_REP_HIGH: target = (reps_left != 4'h0) ? swing : on_level_in;
                endcase
            end
            default: target = rest_level_in;
        endcase
    end

    assign going_up = target > level_out;
    assign step_len = going_up ? fade_in_time_in : fade_out_time_in;
    assign diff     = going_up ? target - level_out : level_out - target;

    // Log fading takes steps proportional to the current level, so low levels move finely.
    always_comb
    begin
        amount = 8'h01;
        if (log_fade_in)
        begin
            amount = (level_out >> 4) + 8'h01;
            if (amount > diff)
            begin
                amount = diff;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            state     <= LIF_ENG_REST;
            dir_up    <= 1'b1;
            reps_left <= 4'h0;
            delay_cnt <= 4'h0;
        end
        else
        begin
            unique case (state)
                LIF_ENG_REST:
                begin
                    if (active_in)
                    begin
                        state     <= LIF_ENG_ACTIVE;
                        dir_up    <= 1'b1;
                        reps_left <= repeat_in;
                    end
                end
                LIF_ENG_ACTIVE:
                begin
                    if (!active_in)
                    begin
                        delay_cnt <= delay_n_in;
                        state     <= (delay_n_in == 4'h0) ? LIF_ENG_REST : LIF_ENG_DELAY;
                    end
                    else if (level_out == target && seq_mode_in != LIF_SEQ_SINGLE)
                    begin
                        if (dir_up)
                        begin
                            dir_up <= 1'b0;
                        end
                        else
                        begin
                            dir_up <= 1'b1;
                            if (seq_mode_in != LIF_SEQ_CONTINUE && reps_left != 4'h0)
                            begin
                                reps_left <= reps_left - 4'h1;
                            end
                        end
                    end
                end
                LIF_ENG_DELAY:
                begin
                    if (active_in)
                    begin
                        state     <= LIF_ENG_ACTIVE;
                        dir_up    <= 1'b1;
                        reps_left <= repeat_in;
                    end
                    else if (delay_tick_in)
                    begin
                        delay_cnt <= delay_cnt - 4'h1;
                        if (delay_cnt == 4'h1)
                        begin
                            state <= LIF_ENG_REST;
                        end
                    end
                end
                default: state <= LIF_ENG_REST;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            level_out <= 8'h00;
            step_cnt  <= 8'h00;
            target_q  <= 8'h00;
        end
        else
        begin
            target_q <= target;
            if (target != target_q)
            begin
                step_cnt <= 8'h00;
            end
            else if (level_out != target && step_tick_in)
            begin
                // A shorter step time written mid-step takes effect at once instead of wrapping.
                if (step_cnt >= step_len)
                begin
                    step_cnt  <= 8'h00;
                    level_out <= going_up ? level_out + amount : level_out - amount;
                end
                else
                begin
                    step_cnt <= step_cnt + 8'h01;
                end
            end
        end
    end

endmodule // lif_fade_engine

// ### lif_led_intensity.sv
`timescale 1ns/10ps
module lif_led_intensity
    import lif_pkg::*;
#(
    parameter int MEAS_CYCLES  = LIF_MEAS_CYCLES,
    parameter int BASE_CYCLES  = LIF_BASE_CYCLES,
    parameter int DELAY_CYCLES = LIF_DELAY_CYCLES,
    parameter int CHANNELS     = 8
)
(
    input  wire logic                clk_in,
    input  wire logic                nrst_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [7:0]          reg_wdata_in,
    input  wire logic                reg_write_in,
    input  wire logic                reg_read_in,
    output logic      [7:0]          reg_rdata_out,
    input  wire logic [CHANNELS-1:0] touch_in,
    input  wire logic                proximity_in,
    input  wire logic                power_state_on_in,
    output logic      [CHANNELS-1:0] led_out,
    output logic                     capacitive_measurement_out
);

    logic [7:0]  regs [LIF_OFF_FIRST:LIF_OFF_LAST];
    logic [31:0] osc_cnt;
    logic        osc_tick;
    logic [7:0]  pwm_div_cnt;
    logic        pwm_tick;
    logic [31:0] base_cnt;
    logic        base_tick;
    logic        eng_step_tick;
    logic        eng_step_phase;
    logic [31:0] delay_cyc;
    logic        delay_tick;
    lif_frame_e  frame;
    logic [31:0] meas_cnt;
    logic [7:0]  pwm_cnt;
    logic        addr_hit;
    logic [7:0]  map_one;
    logic [7:0]  map_two;
    logic [7:0]  seq_cfg;
    logic [7:0]  delay_cfg;
    logic        pwr_enabled;
    logic        eng_one_active;
    logic        eng_two_active;
    logic        pwr_active;
    logic [7:0]  eng_one_level;
    logic [7:0]  eng_two_level;
    logic [7:0]  pwr_level;
    logic [7:0]  pwr_rest;
    logic [7:0]  eng_one_fade;
    logic [7:0]  eng_two_fade;
    logic [7:0]  pwr_fade;
    logic [7:0]  ch_level [CHANNELS];

    assign addr_hit    = reg_addr_in >= LIF_OFF_FIRST && reg_addr_in <= LIF_OFF_LAST;
    assign map_one     = regs[LIF_OFF_MAP_ONE];
    assign map_two     = regs[LIF_OFF_MAP_TWO];
    assign seq_cfg     = regs[LIF_OFF_SEQ_CONFIG];
    assign delay_cfg   = regs[LIF_OFF_RELEASE_DELAY];
    assign pwr_enabled = regs[LIF_OFF_PWR_MODE][LIF_PWR_ENABLE_BIT];

    // Register port. Reserved sequence bit is kept at zero.
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            for (int i = LIF_OFF_FIRST; i <= LIF_OFF_LAST; i++)
            begin
                regs[i] <= LIF_REG_RESET;
            end
        end
        else if (reg_write_in && addr_hit)
        begin
            regs[reg_addr_in] <= reg_wdata_in;
            if (reg_addr_in == LIF_OFF_SEQ_CONFIG)
            begin
                regs[reg_addr_in][LIF_SEQ_RSVD_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (reg_read_in)
        begin
            reg_rdata_out <= addr_hit ? regs[reg_addr_in] : 8'h00;
        end
    end

    // The 2 MHz oscillator is modelled as an enable every 100 system clocks.
    // It restarts with each drive slot, so a slot always spans exactly 255 whole PWM clocks.
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || frame == LIF_FRAME_MEASURE || osc_cnt == 32'(LIF_OSC_CYCLES - 1))
        begin
            osc_cnt <= 32'h0;
        end
        else
        begin
            osc_cnt <= osc_cnt + 32'h1;
        end
    end
    assign osc_tick = osc_cnt == 32'(LIF_OSC_CYCLES - 1);

    // A divisor of zero is treated as one so the PWM clock never stops.
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || frame == LIF_FRAME_MEASURE)
        begin
            pwm_div_cnt <= 8'h00;
        end
        else if (osc_tick)
        begin
            pwm_div_cnt <= pwm_tick ? 8'h00 : pwm_div_cnt + 8'h01;
        end
    end
    assign pwm_tick = osc_tick && (pwm_div_cnt + 8'h01 >= regs[LIF_OFF_PWM_DIVISOR]);

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || base_tick)
        begin
            base_cnt <= 32'h0;
        end
        else
        begin
            base_cnt <= base_cnt + 32'h1;
        end
    end
    assign base_tick = base_cnt == 32'(BASE_CYCLES - 1);

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            eng_step_phase <= 1'b0;
        end
        else if (base_tick)
        begin
            eng_step_phase <= ~eng_step_phase;
        end
    end
    // Two base ticks of 250 us make one engine step unit.
    assign eng_step_tick = base_tick && eng_step_phase == 1'(LIF_ENG_STEP_TICKS - 1);

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || delay_tick)
        begin
            delay_cyc <= 32'h0;
        end
        else
        begin
            delay_cyc <= delay_cyc + 32'h1;
        end
    end
    assign delay_tick = delay_cyc == 32'(DELAY_CYCLES - 1);

    // Frame sequencer: measurement slot, then 255 PWM clocks of drive.
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            frame    <= LIF_FRAME_MEASURE;
            meas_cnt <= 32'h0;
            pwm_cnt  <= 8'h00;
        end
        else
        begin
            unique case (frame)
                LIF_FRAME_MEASURE:
                begin
                    meas_cnt <= meas_cnt + 32'h1;
                    if (meas_cnt == 32'(MEAS_CYCLES - 1))
                    begin
                        meas_cnt <= 32'h0;
                        pwm_cnt  <= 8'h00;
                        frame    <= LIF_FRAME_DRIVE;
                    end
                end
                LIF_FRAME_DRIVE:
                begin
                    if (pwm_tick)
                    begin
                        pwm_cnt <= pwm_cnt + 8'h01;
                        if (pwm_cnt == 8'(LIF_PWM_SLOT_CLOCKS - 1))
                        begin
                            frame <= LIF_FRAME_MEASURE;
                        end
                    end
                end
            endcase
        end
    end
    assign capacitive_measurement_out = frame == LIF_FRAME_MEASURE;

    assign eng_one_active = |(touch_in & map_one) || (proximity_in && |map_one);
    assign eng_two_active = |(touch_in & map_two) || (proximity_in && |map_two);
    assign pwr_active     = pwr_enabled && touch_in[LIF_PWR_CHANNEL];
    // With the set switched off the power button rests at its off level.
    assign pwr_rest       = power_state_on_in ? regs[LIF_OFF_PWR_REST] : regs[LIF_OFF_PWR_LOW];
    assign eng_one_fade   = regs[LIF_OFF_ENG1_TIMING];
    assign eng_two_fade   = regs[LIF_OFF_ENG2_TIMING];
    assign pwr_fade       = regs[LIF_OFF_PWR_TIMING];

    lif_fade_engine u_engine_one
    (
        .clk_in           (clk_in),
        .nrst_in          (nrst_in),
        .step_tick_in     (eng_step_tick),
        .delay_tick_in    (delay_tick),
        .active_in        (eng_one_active),
        .on_level_in      (regs[LIF_OFF_ENG1_LEVEL]),
        .rest_level_in    (regs[LIF_OFF_SHARED_IDLE]),
        .fade_in_time_in  ({4'h0, eng_one_fade[LIF_HI_NIBBLE_LSB +: 4]}),
        .fade_out_time_in ({4'h0, eng_one_fade[LIF_LO_NIBBLE_LSB +: 4]}),
        .delay_n_in       (delay_cfg[LIF_HI_NIBBLE_LSB +: 4]),
        .seq_mode_in      (seq_cfg[LIF_SEQ_MODE_LSB +: 2]),
        .repeat_in        (seq_cfg[LIF_SEQ_REPEAT_LSB +: 4]),
        .log_fade_in      (seq_cfg[LIF_SEQ_LOG_BIT]),
        .level_out        (eng_one_level)
    );

    lif_fade_engine u_engine_two
    (
        .clk_in           (clk_in),
        .nrst_in          (nrst_in),
        .step_tick_in     (eng_step_tick),
        .delay_tick_in    (delay_tick),
        .active_in        (eng_two_active),
        .on_level_in      (regs[LIF_OFF_ENG2_LEVEL]),
        .rest_level_in    (regs[LIF_OFF_SHARED_IDLE]),
        .fade_in_time_in  ({4'h0, eng_two_fade[LIF_HI_NIBBLE_LSB +: 4]}),
        .fade_out_time_in ({4'h0, eng_two_fade[LIF_LO_NIBBLE_LSB +: 4]}),
        .delay_n_in       (delay_cfg[LIF_LO_NIBBLE_LSB +: 4]),
        .seq_mode_in      (seq_cfg[LIF_SEQ_MODE_LSB +: 2]),
        .repeat_in        (seq_cfg[LIF_SEQ_REPEAT_LSB +: 4]),
        .log_fade_in      (seq_cfg[LIF_SEQ_LOG_BIT]),
        .level_out        (eng_two_level)
    );

    // The power engine steps on the 250 us base tick and follows touches directly.
    lif_fade_engine u_engine_power
    (
        .clk_in           (clk_in),
        .nrst_in          (nrst_in),
        .step_tick_in     (base_tick),
        .delay_tick_in    (delay_tick),
        .active_in        (pwr_active),
        .on_level_in      (regs[LIF_OFF_PWR_ACTIVE]),
        .rest_level_in    (pwr_rest),
        .fade_in_time_in  (pwr_fade),
        .fade_out_time_in (pwr_fade),
        .delay_n_in       (4'h0),
        .seq_mode_in      (LIF_SEQ_SINGLE),
        .repeat_in        (4'h0),
        .log_fade_in      (1'b0),
        .level_out        (pwr_level)
    );

    // A channel mapped to both engines shows the brighter of the two, unless it is the power channel with power mode enabled.
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++)
        begin : g_channel
            logic [7:0] sel_one;
            logic [7:0] sel_two;
            assign sel_one = map_one[ch] ? eng_one_level : 8'h00;
            assign sel_two = map_two[ch] ? eng_two_level : 8'h00;
            if (ch == LIF_PWR_CHANNEL)
            begin : g_power
                assign ch_level[ch] = pwr_enabled ? pwr_level :
                                      ((sel_one > sel_two) ? sel_one : sel_two);
            end
            else
            begin : g_plain
                assign ch_level[ch] = (sel_one > sel_two) ? sel_one : sel_two;
            end

            always_ff @(posedge clk_in)
            begin
                if (!nrst_in)
                begin
                    led_out[ch] <= 1'b0;
                end
                else
                begin
                    led_out[ch] <= frame == LIF_FRAME_DRIVE && pwm_cnt < ch_level[ch];
                end
            end
        end
    endgenerate

endmodule // lif_led_intensity

// ### lif_assertions.sv
`timescale 1ns/10ps
module lif_assertions
    import lif_pkg::*;
#(
    parameter int MEAS_CYCLES  = LIF_MEAS_CYCLES,
    parameter int BASE_CYCLES  = LIF_BASE_CYCLES,
    parameter int DELAY_CYCLES = LIF_DELAY_CYCLES,
    parameter int CHANNELS     = 8
)
(
    input wire logic                clk_in,
    input wire logic                nrst_in,
    input wire logic [7:0]          reg_addr_in,
    input wire logic [7:0]          reg_wdata_in,
    input wire logic                reg_write_in,
    input wire logic                reg_read_in,
    input wire logic [7:0]          reg_rdata_out,
    input wire logic [CHANNELS-1:0] touch_in,
    input wire logic                proximity_in,
    input wire logic                power_state_on_in,
    input wire logic [CHANNELS-1:0] led_out,
    input wire logic                capacitive_measurement_out
);
    // Checks assume a divisor of one, the only value the bench programs.
    localparam int DRIVE_CYCLES = LIF_PWM_SLOT_CLOCKS * LIF_OSC_CYCLES;
    wire         meas = capacitive_measurement_out;
    logic [31:0] high_cnt;
    logic [31:0] low_cnt;
    logic        seen_rise;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // The first slot after reset is skipped since its start is not seen.
    always_ff @(posedge clk_in)
    begin
        high_cnt  <= (!nrst_in || !meas) ? 32'h0 : high_cnt + 32'h1;
        low_cnt   <= (!nrst_in || meas) ? 32'h0 : low_cnt + 32'h1;
        seen_rise <= nrst_in && (seen_rise || $rose(meas));
    end

    sequence wr_s;
        reg_write_in && !reg_read_in && reg_addr_in != LIF_OFF_SEQ_CONFIG
            && reg_addr_in >= LIF_OFF_FIRST && reg_addr_in <= LIF_OFF_LAST;
    endsequence
    sequence rd_s;
        reg_read_in && !reg_write_in && $stable(reg_addr_in);
    endsequence

    meas_len_a: assert property ($fell(meas) && seen_rise |-> high_cnt == MEAS_CYCLES)
        else $error("measurement slot length wrong");
    drive_len_a: assert property ($rose(meas) |-> low_cnt == DRIVE_CYCLES)
        else $error("drive slot length wrong");
    meas_dark_a: assert property (meas && $past(meas) |-> led_out == '0)
        else $error("led driven during measurement");
    led_lag_a: assert property ($fell(meas) |-> led_out == '0)
        else $error("led ahead of drive slot");
    unmapped_rd_a: assert property (reg_read_in && (reg_addr_in < LIF_OFF_FIRST ||
        reg_addr_in > LIF_OFF_LAST) |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    rsvd_bit_a: assert property (reg_read_in && reg_addr_in == LIF_OFF_SEQ_CONFIG
        |=> !reg_rdata_out[LIF_SEQ_RSVD_BIT]) else $error("reserved bit reads one");
    rdata_hold_a: assert property (!reg_read_in |=> $stable(reg_rdata_out))
        else $error("read data changed without read");
    write_read_a: assert property (wr_s ##1 rd_s |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("read back differs from write");
endmodule // lif_assertions

bind lif_led_intensity lif_assertions #(.MEAS_CYCLES(MEAS_CYCLES), .BASE_CYCLES(BASE_CYCLES),
    .DELAY_CYCLES(DELAY_CYCLES), .CHANNELS(CHANNELS)) u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .touch_in(touch_in),
    .proximity_in(proximity_in), .power_state_on_in(power_state_on_in), .led_out(led_out),
    .capacitive_measurement_out(capacitive_measurement_out));

// ### lif_led_load.sv
`timescale 1ns/10ps
module lif_led_load
    import lif_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic [7:0]  led_in,
    input  wire logic        meas_in,
    output logic [7:0][15:0] lit_out,
    output logic             done_out
);
    logic [7:0][15:0] acc;
    logic [1:0]       meas_d;
    wire              snap = meas_in && meas_d == 2'h1;

    // Snapshot on the second measurement cycle so the lagging last drive cycle is counted.
    always_ff @(posedge clk_in)
    begin
        meas_d   <= {meas_d[0], meas_in};
        done_out <= nrst_in && snap;
        for (int i = 0; i < 8; i++)
        begin
            acc[i]     <= (!nrst_in || snap) ? 16'h0 : acc[i] + 16'(led_in[i]);
            lit_out[i] <= snap ? acc[i] + 16'(led_in[i]) : lit_out[i];
        end
    end
endmodule // lif_led_load

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import lif_pkg::*;
    localparam int MEAS = 6000;
    logic             clk_in;
    logic             nrst_in;
    logic             wr_en;
    logic             rd_en;
    logic             pwr_on;
    logic             meas;
    logic             done;
    logic [7:0]       addr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic [7:0]       touch;
    logic [7:0]       led;
    logic [7:0]       d;
    logic [7:0][15:0] lit;
    logic [7:0]       lv [4];
    int               err_count;
    int               comparisons;

    // A long measurement slot lets every fade settle before a drive slot is measured.
    lif_led_intensity #(.MEAS_CYCLES(MEAS), .BASE_CYCLES(10), .DELAY_CYCLES(200), .CHANNELS(8)) uut (
        .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata), .touch_in(touch),
        .proximity_in(1'b0), .power_state_on_in(pwr_on), .led_out(led),
        .capacitive_measurement_out(meas));
    lif_led_load load (.clk_in(clk_in), .nrst_in(nrst_in), .led_in(led), .meas_in(meas),
        .lit_out(lit), .done_out(done));

    function automatic logic [15:0] exp_lit(input logic [7:0] lvl);
        return 16'(lvl) * 16'(LIF_OSC_CYCLES);
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] v);
        return (a == LIF_OFF_SEQ_CONFIG) ? (v & 8'hf7) : v;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk_in);
    endtask
    // The write strobe stays up between back-to-back writes and is dropped by the next read.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wr_en <= 1'b0;
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_in);
        rd_en <= 1'b0;
        @(negedge clk_in);
        chk(16'(rdata), 16'(exp));
        @(posedge clk_in);
    endtask
    task automatic wait_frame;
        bit seen;
        seen = 1'b0;
        repeat (40000)
        begin
            @(negedge clk_in);
            if (done === 1'b1)
            begin
                seen = 1'b1;
                break;
            end
        end
        if (!seen)
            err_count++;
    endtask
    task final_report;
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (80000) @(posedge clk_in);
        err_count++;
        final_report;
    end

    initial
    begin
        {nrst_in, wr_en, rd_en, addr, wdata, touch} = '0;
        pwr_on = 1'b1;
        void'($urandom(99));
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        chk(16'(meas), 16'h1);
        chk(16'(led), 16'h0);
        @(posedge clk_in);
        for (int a = 32'h0f; a <= 32'h19; a++)
        begin
            d = 8'($urandom);
            rd(8'(a), LIF_REG_RESET);
            wr(8'(a), d);
            rd(8'(a), exp_rd(8'(a), d));
        end
        for (int m = 32'h0; m < 32'h4; m++)
        begin
            d = {4'($urandom), 2'h3, 2'(m)};
            wr(LIF_OFF_SEQ_CONFIG, d);
            rd(LIF_OFF_SEQ_CONFIG, exp_rd(LIF_OFF_SEQ_CONFIG, d));
        end
        wr(8'h20, 8'h5a);
        rd(8'h20, 8'h00);
        rd(8'h0b, 8'h00);
        foreach (lv[i])
            lv[i] = 8'($urandom_range(254, 1));
        wr(LIF_OFF_MAP_ONE, 8'h01);
        wr(LIF_OFF_MAP_TWO, 8'h02);
        wr(LIF_OFF_PWM_DIVISOR, 8'h01);
        wr(LIF_OFF_SEQ_CONFIG, 8'h00);
        wr(LIF_OFF_SHARED_IDLE, lv[0]);
        wr(LIF_OFF_RELEASE_DELAY, 8'h01);
        wr(LIF_OFF_ENG1_LEVEL, 8'hff);
        wr(LIF_OFF_ENG1_TIMING, 8'h00);
        wr(LIF_OFF_ENG2_LEVEL, lv[1]);
        wr(LIF_OFF_ENG2_TIMING, 8'h00);
        wr(LIF_OFF_PWR_REST, lv[2]);
        wr(LIF_OFF_PWR_LOW, lv[3]);
        wr(LIF_OFF_PWR_TIMING, 8'h00);
        wr(LIF_OFF_PWR_MODE, 8'h02);
        // Channel two is touched but mapped to no engine, so it must stay dark.
        wr_en <= 1'b0;
        touch <= 8'h06;
        wait_frame;
        chk(lit[0], exp_lit(lv[0]));
        chk(lit[1], exp_lit(lv[1]));
        for (int i = 2; i < 7; i++)
            chk(lit[i], 16'h0);
        chk(lit[7], exp_lit(lv[2]));
        @(posedge clk_in);
        touch  <= 8'h00;
        pwr_on <= 1'b0;
        wait_frame;
        chk(lit[1], exp_lit(lv[0]));
        chk(lit[0], exp_lit(lv[0]));
        chk(lit[7], exp_lit(lv[3]));
        final_report;
    end
endmodule // tb_top
